//--- rtl/bwp_top.sv
// Overview of operation
// R1 - valid soft-off command drops main rails
// R2 - after ac return restore prior state per policy
// R3 - fans run in working state
// R4 - fans off in s3, s4, s5
// R5 - fans closed loop from temperature and tach
// R6 - network side raises wake on magic frame
// R7 - s3: supply off, amber or dark led
// R8 - wake in s3 returns to working quickly
// R9 - usb activity wakes from s3 only
// R10 - ps2 activity wakes from s1, s3, s4, s5
// R11 - keyboard key wake s4/s5 needs enable
// R12 - pme wakes sleep states only when enabled
// R13 - pcie wake always wakes sleep states
// R14 - standby led lit whenever standby present
// R15 - short press toggles, long press forces off
// R16 - lan/pme wake from s5 off by default
// R17 - ps2 wake from s4/s5 off by default
// R18 - wake pins synchronised, ignored while working
//
// Added by the designer: the register offsets and the APB slave port.
`include "bwp_defs.svh"
module bwp_top import bwp_pkg::*; #(
    parameter int unsigned LONG_PRESS_CYC = `BWP_LONG_PRESS_S * `BWP_CLK_HZ,
    parameter int unsigned FAN_WIN_CYC = `BWP_FAN_WIN_MS * (`BWP_CLK_HZ / 1000)
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // wake sources, asynchronous
    input wire logic i_lan_wake_b,
    input wire logic i_pme_b,
    input wire logic i_pcie_wake_b,
    input wire logic i_usb_act,
    input wire logic i_ps2_act,
    input wire logic i_kbd_key,
    input wire logic i_pwr_sw_b,
    // retained state, fans, temperature
    input wire logic i_last_on,
    input wire logic [1:0] i_tach,
    input wire logic [7:0] i_temp,
    // power supply, fans, indicators
    output logic o_ps_on_b,
    output logic [1:0] o_fan_pwm,
    output logic o_led_green,
    output logic o_led_amber,
    output logic o_sb_led,
    output logic o_last_on,
    output logic o_irq
);
    localparam int PW = $clog2(LONG_PRESS_CYC + 1);

    ////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, accept when stages 2 and 3 agree
    logic [`BWP_NPIN-1:0] pin_raw, s1_q, s2_q, s3_q, pin_q;
    assign pin_raw = {i_tach, i_last_on, ~i_pwr_sw_b, i_kbd_key, i_ps2_act, i_usb_act,
                      ~i_pcie_wake_b, ~i_pme_b, ~i_lan_wake_b};
    for (genvar i = 0; i < `BWP_NPIN; i++) begin : g_sync
        always_ff @(posedge i_clk) begin
            if (!i_rst_b) begin
                s1_q[i] <= 1'b0;
                s2_q[i] <= 1'b0;
                s3_q[i] <= 1'b0;
                pin_q[i] <= 1'b0;
            end else begin
                s1_q[i] <= pin_raw[i]; // R18
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                // glitches that reach only stage 2 are dropped
                if (s2_q[i] == s3_q[i]) begin
                    pin_q[i] <= s3_q[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // registers and apb
    bwp_state_e state_q;
    logic [31:0] ctrl_q, fancfg_q, prdata_q;
    logic [`BWP_NINT-1:0] ist_q, imask_q, iset;
    logic pready_q, pslverr_q, wr_acc, cmd_wr;
    logic [2:0] st_code;
    logic [7:0] fan_spd [2];
    logic [1:0] pol;
    assign wr_acc = i_psel && i_penable && i_pwrite && pready_q;
    assign cmd_wr = wr_acc && (i_paddr == `BWP_A_CMD);
    assign pol = ctrl_q[`BWP_C_POL];

    // state code shown to software
    always_comb begin
        case (state_q)
            st_s0: st_code = `BWP_SC_S0;
            st_s1: st_code = `BWP_SC_S1;
            st_s3: st_code = `BWP_SC_S3;
            st_s4: st_code = `BWP_SC_S4;
            default: st_code = `BWP_SC_S5;
        endcase
    end

    // read data captured in setup so the access phase answers at once
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= i_psel && !i_penable;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            if (i_psel && !i_penable) begin
                if (i_paddr == `BWP_A_CTRL) begin
                    prdata_q <= ctrl_q;
                end else if (i_paddr == `BWP_A_CMD) begin
                    prdata_q <= 32'h0000_0000; // write only
                end else if (i_paddr == `BWP_A_STATE) begin
                    prdata_q <= {27'h0, o_fan_pwm != 2'h0 || state_q == st_s0, !o_ps_on_b, st_code};
                end else if (i_paddr == `BWP_A_ISTAT) begin
                    prdata_q <= {28'h0, ist_q};
                end else if (i_paddr == `BWP_A_IMASK) begin
                    prdata_q <= {28'h0, imask_q};
                end else if (i_paddr == `BWP_A_FANCFG) begin
                    prdata_q <= fancfg_q;
                end else if (i_paddr == `BWP_A_FANSPD) begin
                    prdata_q <= {16'h0, fan_spd[1], fan_spd[0]};
                end else begin
                    pslverr_q <= 1'b1; // unmapped
                end
            end
        end
    end
    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;

    // software writable configuration
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ctrl_q <= `BWP_CTRL_RST; // R16 R17
            fancfg_q <= `BWP_FANCFG_RST;
            imask_q <= '0;
        end else if (wr_acc) begin
            if (i_paddr == `BWP_A_CTRL) begin
                ctrl_q <= {25'h0, i_pwdata[6:0]};
            end else if (i_paddr == `BWP_A_IMASK) begin
                imask_q <= i_pwdata[`BWP_NINT-1:0];
            end else if (i_paddr == `BWP_A_FANCFG) begin
                fancfg_q <= {16'h0, i_pwdata[15:0]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // power switch timing
    logic btn, btn_old_q, long_q, long_hit, short_hit;
    logic [PW-1:0] press_q;
    assign btn = pin_q[`BWP_P_SW];
    assign long_hit = btn && !long_q && (press_q == PW'(LONG_PRESS_CYC - 1)) && state_q != st_s5;
    assign short_hit = btn_old_q && !btn && !long_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            btn_old_q <= 1'b0;
            press_q <= '0;
            long_q <= 1'b0;
        end else begin
            btn_old_q <= btn;
            if (!btn) begin
                press_q <= '0;
                long_q <= 1'b0;
            end else if (press_q == PW'(LONG_PRESS_CYC - 1)) begin
                // a press past the limit never counts as short
                long_q <= 1'b1; // R15
            end else begin
                press_q <= press_q + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // software sleep command decode
    bwp_state_e cmd_st;
    logic cmd_ok, cmd_bad;
    always_comb begin
        cmd_st = st_s5;
        cmd_ok = 1'b0;
        if (cmd_wr && state_q == st_s0) begin
            cmd_ok = 1'b1;
            if (i_pwdata[2:0] == `BWP_SC_S1) begin
                cmd_st = st_s1;
            end else if (i_pwdata[2:0] == `BWP_SC_S3) begin
                cmd_st = st_s3;
            end else if (i_pwdata[2:0] == `BWP_SC_S4) begin
                cmd_st = st_s4;
            end else if (i_pwdata[2:0] == `BWP_SC_S5) begin
                cmd_st = st_s5; // R1
            end else begin
                cmd_ok = 1'b0;
            end
        end
    end
    assign cmd_bad = cmd_wr && !cmd_ok;

    ////////////////////////////////////////////////////////////////
    // wake gating per state and option
    logic deep, light, s5_ok, wake_go;
    assign light = (state_q == st_s1) || (state_q == st_s3);
    assign deep = (state_q == st_s4) || (state_q == st_s5);
    assign s5_ok = (state_q != st_s5) || ctrl_q[`BWP_C_S5]; // R16
    // levels are sampled only while asleep, so activity in s0 is ignored
    assign wake_go = (state_q != st_s0) && ( // R18
        pin_q[`BWP_P_PCIE] || // R13
        (pin_q[`BWP_P_LAN] && s5_ok) ||
        (pin_q[`BWP_P_PME] && ctrl_q[`BWP_C_PME] && s5_ok) || // R12
        (pin_q[`BWP_P_USB] && state_q == st_s3) || // R9
        (pin_q[`BWP_P_PS2] && (light || (deep && ctrl_q[`BWP_C_PS2]))) || // R10 R17
        (pin_q[`BWP_P_KBD] && (light || (deep && ctrl_q[`BWP_C_KBD])))); // R11

    ////////////////////////////////////////////////////////////////
    // restore after standby power returns
    logic [2:0] settle_q;
    logic restore_go, restore_on;
    assign restore_go = (settle_q == `BWP_SETTLE_CYC - 3'h1);
    assign restore_on = (pol == `BWP_POL_ON) || (pol == `BWP_POL_LAST && pin_q[`BWP_P_LAST]);
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            settle_q <= 3'h0;
        end else if (settle_q != `BWP_SETTLE_CYC) begin
            // waits for the synchronisers to carry the retained level
            settle_q <= settle_q + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // power state machine, switch first, then software, then wake
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            state_q <= st_s5;
        end else if (long_hit) begin
            state_q <= st_s5; // R15
        end else if (short_hit) begin
            case (state_q)
                st_s0: state_q <= st_s3; // R15
                default: state_q <= st_s0;
            endcase
        end else if (cmd_ok) begin
            state_q <= cmd_st; // R1
        end else if (wake_go) begin
            state_q <= st_s0; // R8
        end else if (restore_go && restore_on) begin
            state_q <= st_s0; // R2
        end
    end

    ////////////////////////////////////////////////////////////////
    // supply, indicators and retained state
    logic fan_en_q, main_on;
    assign main_on = (state_q == st_s0) || (state_q == st_s1);
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_ps_on_b <= 1'b1;
            o_led_green <= 1'b0;
            o_led_amber <= 1'b0;
            o_sb_led <= 1'b1;
            fan_en_q <= 1'b0;
        end else begin
            o_ps_on_b <= !main_on; // R1 R7
            o_led_green <= main_on;
            // single colour panels stay dark in s3
            o_led_amber <= (state_q == st_s3) && ctrl_q[`BWP_C_LED]; // R7
            o_sb_led <= 1'b1; // R14
            fan_en_q <= (state_q == st_s0); // R3 R4
        end
    end

    // retained on/off level, valid once the restore decision is made
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_last_on <= 1'b0;
        end else if (restore_go) begin
            o_last_on <= pin_q[`BWP_P_LAST];
        end else if (settle_q == `BWP_SETTLE_CYC) begin
            o_last_on <= main_on; // R2
        end
    end

    ////////////////////////////////////////////////////////////////
    // interrupts: sticky, write one to clear, set wins
    assign iset = {cmd_bad, cmd_ok, long_hit || short_hit, wake_go};
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ist_q <= '0;
            o_irq <= 1'b0;
        end else begin
            if (wr_acc && i_paddr == `BWP_A_ISTAT) begin
                ist_q <= (ist_q & ~i_pwdata[`BWP_NINT-1:0]) | iset;
            end else begin
                ist_q <= ist_q | iset;
            end
            o_irq <= |(ist_q & imask_q);
        end
    end

    ////////////////////////////////////////////////////////////////
    // fan channels: cpu fan 0, rear fan 1
    bwp_fan_if fif[2] ();
    for (genvar g = 0; g < 2; g++) begin : g_fan
        logic [7:0] hot;
        // target rises one pulse per degree above threshold
        assign hot = (i_temp > fancfg_q[15:8]) ? i_temp - fancfg_q[15:8] : 8'h00;
        assign fif[g].target = (fancfg_q[7:0] > ~hot) ? `BWP_DUTY_MAX : fancfg_q[7:0] + hot; // R5
        assign fif[g].en = fan_en_q;
        assign fif[g].tach = pin_q[`BWP_P_TACH + g]; // R5
        assign o_fan_pwm[g] = fif[g].pwm;
        assign fan_spd[g] = fif[g].speed;
        bwp_fan #(.WIN_CYC(FAN_WIN_CYC)) u_fan (
            .i_clk(i_clk),
            .i_rst_b(i_rst_b),
            .f(fif[g].fan)
        );
    end

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    sequence seq_softoff;
        cmd_ok && i_pwdata[2:0] == `BWP_SC_S5 && !long_hit && !short_hit;
    endsequence
    sequence seq_asleep3;
        (state_q != st_s0) [*3];
    endsequence
    a_softoff_rails: assert property (seq_softoff |=> state_q == st_s5 ##1 o_ps_on_b) // R1
        else $error("soft-off did not drop main rails");
    a_restore_on: assert property (restore_go && pol == `BWP_POL_ON && state_q == st_s5 && !btn
        |=> state_q == st_s0 ##1 !o_ps_on_b) // R2
        else $error("restore policy on did not power up");
    a_fans_idle: assert property (seq_asleep3 |-> o_fan_pwm == 2'h0) // R4
        else $error("fan driven outside working state");
    a_s3_panel: assert property (state_q == st_s3 |=> o_ps_on_b && !o_led_green) // R7
        else $error("s3 supply or panel led wrong");
    a_wake_s3: assert property (state_q == st_s3 && wake_go && !btn && !btn_old_q |=> state_q == st_s0) // R8
        else $error("wake in s3 not honoured");
    a_usb_deep: assert property (deep && pin_q[`BWP_NPIN-6:0] == 5'h08 && !pin_q[`BWP_P_KBD]
        && !ctrl_q[`BWP_C_PME] |-> !wake_go) // R9
        else $error("usb woke from s4 or s5");
    a_pcie_wake: assert property (state_q != st_s0 && pin_q[`BWP_P_PCIE] |-> wake_go) // R13
        else $error("pcie wake ignored");
    a_sb_led: assert property (1'b1 |=> o_sb_led) // R14
        else $error("standby led dark");
    a_long_off: assert property (long_hit |=> state_q == st_s5 ##1 o_ps_on_b) // R15
        else $error("long press did not force soft-off");
    a_s5_lan_off: assert property (state_q == st_s5 && !ctrl_q[`BWP_C_S5] && pin_q[6:2] == 5'h00 |-> !wake_go) // R16
        else $error("lan or pme woke from s5 while disabled");
    a_s0_hold: assert property (state_q == st_s0 && !cmd_ok && !short_hit && !long_hit |=> state_q == st_s0) // R18
        else $error("wake source disturbed working state");
endmodule

//--- rtl/bwp_defs.svh
`ifndef BWP_DEFS_SVH
`define BWP_DEFS_SVH
// clock and timing
`define BWP_CLK_HZ 10000000
`define BWP_LONG_PRESS_S 4
`define BWP_FAN_WIN_MS 100
`define BWP_SETTLE_CYC 3'h6
// apb register byte addresses
`define BWP_A_CTRL 8'h00
`define BWP_A_CMD 8'h04
`define BWP_A_STATE 8'h08
`define BWP_A_ISTAT 8'h0c
`define BWP_A_IMASK 8'h10
`define BWP_A_FANCFG 8'h14
`define BWP_A_FANSPD 8'h18
// ctrl fields and reset value
`define BWP_C_PME 0
`define BWP_C_S5 1
`define BWP_C_PS2 2
`define BWP_C_KBD 3
`define BWP_C_POL 5:4
`define BWP_C_LED 6
`define BWP_CTRL_RST 32'h0000_0060
`define BWP_FANCFG_RST 32'h0000_2840
// restore policy codes
`define BWP_POL_OFF 2'h0
`define BWP_POL_ON 2'h1
`define BWP_POL_LAST 2'h2
// state codes as seen by software
`define BWP_SC_S0 3'h0
`define BWP_SC_S1 3'h1
`define BWP_SC_S3 3'h3
`define BWP_SC_S4 3'h4
`define BWP_SC_S5 3'h5
// interrupt status bits
`define BWP_NINT 4
`define BWP_I_WAKE 0
`define BWP_I_BTN 1
`define BWP_I_SLP 2
`define BWP_I_BAD 3
// synchronised pin indices
`define BWP_NPIN 10
`define BWP_P_LAN 0
`define BWP_P_PME 1
`define BWP_P_PCIE 2
`define BWP_P_USB 3
`define BWP_P_PS2 4
`define BWP_P_KBD 5
`define BWP_P_SW 6
`define BWP_P_LAST 7
`define BWP_P_TACH 8
// fan loop
`define BWP_DUTY_START 8'h80
`define BWP_DUTY_MAX 8'hff
`endif

//--- rtl/bwp_pkg.sv
package bwp_pkg;
    // power states tracked by the sequencer
    typedef enum logic [2:0] {st_s0, st_s1, st_s3, st_s4, st_s5} bwp_state_e;
endpackage

//--- rtl/bwp_fan_if.sv
interface bwp_fan_if;
    logic en;          // fan allowed to run
    logic [7:0] target; // wanted tach pulses per window
    logic tach;        // synchronised tach level
    logic pwm;         // drive to fan header
    logic [7:0] speed; // last measured pulses per window
    modport ctl (output en, output target, output tach, input pwm, input speed);
    modport fan (input en, input target, input tach, output pwm, output speed);
endinterface

//--- rtl/bwp_fan.sv
`include "bwp_defs.svh"
module bwp_fan import bwp_pkg::*; #(
    parameter int unsigned WIN_CYC = `BWP_FAN_WIN_MS * (`BWP_CLK_HZ / 1000)
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // fan channel
    bwp_fan_if.fan f
);
    localparam int WW = $clog2(WIN_CYC + 1);
    logic [WW-1:0] win_q;   // measurement window timer
    logic [7:0] pulse_q;    // tach rising edges this window
    logic [7:0] duty_q;     // current pwm duty
    logic [7:0] pwm_cnt_q;  // free running pwm ramp
    logic tach_old_q;       // tach edge detect
    logic pwm_q;
    logic [7:0] speed_q;
    logic win_end;

    assign win_end = (win_q == WW'(WIN_CYC - 1));
    assign f.pwm = pwm_q;
    assign f.speed = speed_q;

    ////////////////////////////////////////////////////////////////
    // window timer and tach pulse counting
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            win_q <= '0;
            pulse_q <= 8'h00;
            speed_q <= 8'h00;
            tach_old_q <= 1'b0;
        end else begin
            tach_old_q <= f.tach;
            win_q <= win_end ? '0 : win_q + 1'b1;
            if (win_end) begin
                speed_q <= pulse_q;
                pulse_q <= 8'h00;
            end else if (f.tach && !tach_old_q && pulse_q != 8'hff) begin
                // saturate so a fast fan never wraps to slow
                pulse_q <= pulse_q + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // closed loop: one duty step per window toward the target
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            duty_q <= `BWP_DUTY_START;
        end else if (!f.en) begin
            // restart from mid duty so spin-up is quick
            duty_q <= `BWP_DUTY_START;
        end else if (win_end) begin
            if (pulse_q < f.target && duty_q != `BWP_DUTY_MAX) begin
                duty_q <= duty_q + 8'h01; // R5
            end else if (pulse_q > f.target && duty_q != 8'h00) begin
                duty_q <= duty_q - 8'h01; // R5
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // pwm generator, held low while the fan is disabled
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            pwm_cnt_q <= 8'h00;
            pwm_q <= 1'b0;
        end else begin
            pwm_cnt_q <= pwm_cnt_q + 8'h01;
            pwm_q <= f.en && (pwm_cnt_q < duty_q);
        end
    end
endmodule

//--- test/bwp_board.sv
// stand-in for the wake peripherals and fan tach lines
module bwp_board (
    // clock
    input wire logic i_clk,
    // requests from the bench: lan, pme, pcie, usb, ps2, kbd, switch
    input wire logic [6:0] i_req,
    // fan drive from the board
    input wire logic [1:0] i_fan_pwm,
    // pins toward the board
    output logic o_lan_wake_b,
    output logic o_pme_b,
    output logic o_pcie_wake_b,
    output logic o_usb_act,
    output logic o_ps2_act,
    output logic o_kbd_key,
    output logic o_pwr_sw_b,
    output logic [1:0] o_tach
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] spin0_q; // rotation progress, cpu fan
    logic [3:0] spin1_q; // rotation progress, rear fan
    ////////////////////////////////////////////////////////////
    // idle levels at time zero: active-low lines pulled high
    initial begin
        {o_lan_wake_b, o_pme_b, o_pcie_wake_b, o_pwr_sw_b} = 4'hf;
        {o_usb_act, o_ps2_act, o_kbd_key} = 3'h0;
        {spin0_q, spin1_q} = 8'h00;
        o_tach = 2'h0;
    end
    ////////////////////////////////////////////////////////////
    // pins follow the requests one edge late, like a slow peripheral
    always @(posedge i_clk) begin
        o_lan_wake_b <= ~i_req[0];
        o_pme_b <= ~i_req[1];
        o_pcie_wake_b <= ~i_req[2];
        o_usb_act <= i_req[3];
        o_ps2_act <= i_req[4];
        o_kbd_key <= i_req[5];
        o_pwr_sw_b <= ~i_req[6];
        // fan spins only while driven, so tach stops when unpowered
        spin0_q <= spin0_q + {3'h0, i_fan_pwm[0]};
        spin1_q <= spin1_q + {3'h0, i_fan_pwm[1]};
        o_tach <= {spin1_q[2], spin0_q[2]};
    end
endmodule

//--- test/bwp_top_test.sv
`include "bwp_defs.svh"
module bwp_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, ps_on_b, green, amber, sb_led, irq;
    logic [6:0] req = 7'h00; // wake requests to the partner
    logic lan_b, pme_b, pcie_b, usb, ps2, kbd, sw_b;
    logic [1:0] tach, pwm;
    logic [31:0] rdat; // last read word
    logic rerr; // last slave error
    logic last_on = 1'b0; // retained level from before power loss
    logic last_out; // retained level the board hands back
    int num_errors = 0;
    int checks = 0;
    ////////////////////////////////////////////////////////////
    // short counts keep the run brief
    bwp_top #(.LONG_PRESS_CYC(64), .FAN_WIN_CYC(256)) u_dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_lan_wake_b(lan_b), .i_pme_b(pme_b), .i_pcie_wake_b(pcie_b), .i_usb_act(usb),
        .i_ps2_act(ps2), .i_kbd_key(kbd), .i_pwr_sw_b(sw_b), .i_last_on(last_on),
        .i_tach(tach), .i_temp(8'h20), .o_ps_on_b(ps_on_b), .o_fan_pwm(pwm),
        .o_led_green(green), .o_led_amber(amber), .o_sb_led(sb_led), .o_last_on(last_out),
        .o_irq(irq));
    bwp_board u_board (
        .i_clk(i_clk), .i_req(req), .i_fan_pwm(pwm), .o_lan_wake_b(lan_b),
        .o_pme_b(pme_b), .o_pcie_wake_b(pcie_b), .o_usb_act(usb), .o_ps2_act(ps2),
        .o_kbd_key(kbd), .o_pwr_sw_b(sw_b), .o_tach(tach));
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so a following call never reassigns psel in this step
        @(posedge i_clk);
        if (n >= 20) begin
            chk(32'h0, 32'h1, "apb timeout");
            final_report();
        end
    endtask
    // poll the state code, bounded
    task automatic wait_state(input logic [2:0] code);
        int n;
        n = 0;
        do begin
            apb(1'b0, `BWP_A_STATE, 32'h0);
            n++;
        end while (rdat[2:0] !== code && n < 40);
        chk({29'h0, rdat[2:0]}, {29'h0, code}, "state not reached");
        if (rdat[2:0] !== code) begin
            final_report();
        end
    endtask
    task automatic press(input int cyc);
        req[6] <= 1'b1;
        repeat (cyc) @(posedge i_clk);
        req[6] <= 1'b0;
    endtask
    // pulse a wake pin while asleep and expect no wake
    task automatic no_wake(input int idx, input logic [2:0] code);
        req[idx] <= 1'b1;
        repeat (20) @(posedge i_clk);
        wait_state(code);
        req[idx] <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask
    // hold a wake pin until working, then drop it so it does not re-wake
    task automatic wake(input int idx);
        req[idx] <= 1'b1;
        wait_state(`BWP_SC_S0);
        req[idx] <= 1'b0;
        repeat (8) @(posedge i_clk);
    endtask
    ////////////////////////////////////////////////////////////
    // reset defaults, unmapped access, restore with last state off
    task automatic t_reset;
        chk({31'h0, sb_led}, 32'h1, "standby led dark");
        apb(1'b0, `BWP_A_CTRL, 32'h0);
        chk(rdat, `BWP_CTRL_RST, "ctrl default");
        apb(1'b0, 8'h1c, 32'h0);
        chk({31'h0, rerr}, 32'h1, "unmapped without error");
        wait_state(`BWP_SC_S5);
        chk({31'h0, ps_on_b}, 32'h1, "supply on after restore off");
    endtask
    // short press powers on, fans run and report speed
    task automatic t_power_on;
        press(10);
        wait_state(`BWP_SC_S0);
        // read again: the supply flag lags the state by one edge
        apb(1'b0, `BWP_A_STATE, 32'h0);
        chk(rdat, 32'h18, "working status word");
        repeat (600) @(posedge i_clk);
        chk({31'h0, ps_on_b | ~green}, 32'h0, "supply or led off in s0");
        apb(1'b0, `BWP_A_FANSPD, 32'h0);
        chk({31'h0, rdat[7:0] != 8'h00 && rdat[15:8] != 8'h00}, 32'h1, "no fan speed measured");
    endtask
    // sleep command, indicators, interrupt, usb wake, soft-off
    task automatic t_sleep;
        apb(1'b1, `BWP_A_CMD, 32'h2);
        wait_state(`BWP_SC_S0);
        apb(1'b1, `BWP_A_IMASK, 32'hf);
        apb(1'b1, `BWP_A_ISTAT, 32'hf);
        apb(1'b1, `BWP_A_CMD, {29'h0, `BWP_SC_S3});
        wait_state(`BWP_SC_S3);
        repeat (3) @(posedge i_clk);
        chk({28'h0, ps_on_b, amber, green, irq}, 32'hd, "s3 outputs");
        chk({30'h0, pwm}, 32'h0, "fans run in s3");
        apb(1'b1, `BWP_A_ISTAT, 32'hf);
        repeat (3) @(posedge i_clk);
        chk({31'h0, irq}, 32'h0, "irq stuck after clear");
        wake(3);
        apb(1'b1, `BWP_A_CMD, {29'h0, `BWP_SC_S5});
        wait_state(`BWP_SC_S5);
        chk({31'h0, ps_on_b}, 32'h1, "main supply still on");
        no_wake(3, `BWP_SC_S5);
        no_wake(1, `BWP_SC_S5);
        no_wake(4, `BWP_SC_S5);
    endtask
    // pme enables, pcie and ps2 wakes, long press, keyboard enable
    task automatic t_wakes;
        apb(1'b1, `BWP_A_CTRL, 32'h63);
        wake(1);
        apb(1'b1, `BWP_A_CMD, {29'h0, `BWP_SC_S4});
        wait_state(`BWP_SC_S4);
        wake(2);
        apb(1'b1, `BWP_A_CMD, {29'h0, `BWP_SC_S1});
        wait_state(`BWP_SC_S1);
        wake(4);
        press(90);
        wait_state(`BWP_SC_S5);
        no_wake(5, `BWP_SC_S5);
        apb(1'b1, `BWP_A_CTRL, 32'h68);
        wake(5);
        chk({31'h0, sb_led}, 32'h1, "standby led dark");
    endtask
    // mid-run power loss, then restore by the given policy and retained level
    task automatic t_restore(input logic [31:0] c, input logic lo);
        last_on <= lo;
        i_rst_b <= 1'b0;
        repeat (4) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        apb(1'b1, `BWP_A_CTRL, c);
        wait_state(`BWP_SC_S0);
        chk({30'h0, ps_on_b, last_out}, 32'h1, "restore did not power on");
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        t_reset();
        t_power_on();
        t_sleep();
        t_wakes();
        t_restore(32'h50, 1'b0);
        t_restore(32'h60, 1'b1);
        final_report();
    end
endmodule
